// ==== rtl/gpio_defines.svh ====
// holds register offsets, widths and reset values for the three i/o ports
// assumes inclusion by the port block and its helpers only
`ifndef GPIO_DEFINES_SVH
`define GPIO_DEFINES_SVH
`define GPIO_ADDR_W 8
`define GPIO_DATA_W 8
`define GPIO_FIRST_DATA 8'h12
`define GPIO_FIRST_DIR 8'h13
`define GPIO_SECOND_DATA 8'h14
`define GPIO_SECOND_DIR 8'h15
`define GPIO_THIRD_DATA 8'h16
`define GPIO_THIRD_DIR 8'h17
`define GPIO_FIRST_W 8
`define GPIO_SECOND_W 8
`define GPIO_THIRD_W 5
`define GPIO_DIR_RESET 8'hff
`define GPIO_LATCH_RESET 8'hff
`define GPIO_LINE_TONE 0
`define GPIO_LINE_TONE_N 1
`define GPIO_LINE_OSC_IN 3
`define GPIO_LINE_OSC_OUT 4
`endif

// ==== rtl/gpio_pkg.sv ====
// holds the shared types of the i/o port block
// assumes the defines header is included before use
`include "gpio_defines.svh"
package gpio_pkg;
    typedef logic [`GPIO_DATA_W-1:0] gpio_byte_t;
    typedef logic [`GPIO_ADDR_W-1:0] gpio_addr_t;
endpackage

// ==== rtl/gpio_sync.sv ====
// holds a two-stage synchroniser for pad levels
// assumes one clock and an active-low asynchronous reset
`timescale 1ns/1ps
module gpio_sync #(
    parameter int WIDTH = 8
) (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] first;
        logic [WIDTH-1:0] second;
    } gpio_sync_s;
    gpio_sync_s state;
    gpio_sync_s next_state;
    always_comb begin
        next_state.first = async_in;
        next_state.second = state.first;
    end
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            // reset to the pulled idle level so no false edge follows reset
            state <= '1;
        end else begin
            state <= next_state;
        end
    end
    assign sync_out = state.second;
endmodule // gpio_sync

// ==== rtl/gpio_port.sv ====
// holds one port: data latch, direction register, pad drive and read mux
// assumes pad levels arrive already synchronised
`timescale 1ns/1ps
`include "gpio_defines.svh"
module gpio_port #(
    parameter int WIDTH = 8
) (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic data_we_in,
    input wire logic dir_we_in,
    input wire logic [7:0] wdata_in,
    input wire logic [WIDTH-1:0] pad_sync_in,
    output logic [WIDTH-1:0] latch_out,
    output logic [WIDTH-1:0] dir_out,
    output logic [7:0] data_rd_out,
    output logic [7:0] dir_rd_out
);
    typedef struct packed {
        logic [WIDTH-1:0] latch;
        logic [WIDTH-1:0] dir;
    } gpio_port_s;
    gpio_port_s state;
    gpio_port_s next_state;
    logic [WIDTH-1:0] mixed;
    if (WIDTH < 1 || WIDTH > `GPIO_DATA_W) begin : g_width_check
        $error("port width must be 1 to 8");
    end
    always_comb begin
        next_state = state;
        if (data_we_in) begin
            next_state.latch = wdata_in[WIDTH-1:0];
        end
        if (dir_we_in) begin
            next_state.dir = wdata_in[WIDTH-1:0];
        end
    end
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state.latch <= WIDTH'(`GPIO_LATCH_RESET);
            state.dir <= WIDTH'(`GPIO_DIR_RESET);
        end else begin
            state <= next_state;
        end
    end
    assign mixed = (state.dir & pad_sync_in) | (~state.dir & state.latch);
    assign latch_out = state.latch;
    assign dir_out = state.dir;
    assign data_rd_out = 8'(mixed);
    assign dir_rd_out = 8'(state.dir);
endmodule // gpio_port

// ==== rtl/gpio_top.sv ====
// holds the three-port i/o block with buzzer sharing and wake-up
// assumes the cpu bus strobes on the instruction clock; pads are asynchronous
`timescale 1ns/1ps
`include "gpio_defines.svh"
module gpio_top #(
    parameter int FIRST_W = `GPIO_FIRST_W,
    parameter int SECOND_W = `GPIO_SECOND_W,
    parameter int THIRD_W = `GPIO_THIRD_W
) (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire gpio_pkg::gpio_addr_t addr_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire gpio_pkg::gpio_byte_t wdata_in,
    output gpio_pkg::gpio_byte_t rdata_out,
    input wire logic second_instruction_phase_in,
    input wire logic timer_overflow_in,
    input wire logic opt_wake_first_in,
    input wire logic opt_pull_first_in,
    input wire logic opt_pull_second_in,
    input wire logic opt_pull_third_in,
    input wire logic opt_buzzer_in,
    input wire logic opt_rc_io_in,
    input wire logic [FIRST_W-1:0] first_port_in,
    output logic [FIRST_W-1:0] first_port_out,
    output logic [FIRST_W-1:0] first_port_oe_n_out,
    output logic [FIRST_W-1:0] first_port_pull_out,
    input wire logic [SECOND_W-1:0] second_port_in,
    output logic [SECOND_W-1:0] second_port_out,
    output logic [SECOND_W-1:0] second_port_oe_n_out,
    output logic [SECOND_W-1:0] second_port_pull_out,
    input wire logic [THIRD_W-1:0] third_port_in,
    output logic [THIRD_W-1:0] third_port_out,
    output logic [THIRD_W-1:0] third_port_oe_n_out,
    output logic [THIRD_W-1:0] third_port_pull_out,
    output logic ext_interrupt_n_out,
    output logic timer_ext_clock_pin_out,
    output logic wake_out
);
    import gpio_pkg::*;
    typedef struct packed {
        logic tone;
        logic wake;
        gpio_byte_t rdata;
        logic [FIRST_W-1:0] p1_o;
        logic [FIRST_W-1:0] p1_oe_n;
        logic [FIRST_W-1:0] p1_pull;
        logic [SECOND_W-1:0] p2_o;
        logic [SECOND_W-1:0] p2_oe_n;
        logic [SECOND_W-1:0] p2_pull;
        logic [THIRD_W-1:0] p3_o;
        logic [THIRD_W-1:0] p3_oe_n;
        logic [THIRD_W-1:0] p3_pull;
        logic irq_n;
        logic tmr_clk;
        logic [FIRST_W-1:0] p1_prev;
    } gpio_top_s;
    gpio_top_s state;
    gpio_top_s next_state;
    // ******************************************
    // elaboration checks
    // ******************************************
    if (FIRST_W != `GPIO_FIRST_W || SECOND_W != `GPIO_SECOND_W || THIRD_W != `GPIO_THIRD_W) begin : g_width_check
        $error("port widths must be 8, 8 and 5");
    end
    // ******************************************
    // pad synchronisers
    // ******************************************
    logic [FIRST_W-1:0] p1_sync;
    logic [SECOND_W-1:0] p2_sync;
    logic [THIRD_W-1:0] p3_sync;
    gpio_sync #(.WIDTH(FIRST_W)) u_sync1 (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .async_in(first_port_in),
        .sync_out(p1_sync)
    );
    gpio_sync #(.WIDTH(SECOND_W)) u_sync2 (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .async_in(second_port_in),
        .sync_out(p2_sync)
    );
    gpio_sync #(.WIDTH(THIRD_W)) u_sync3 (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .async_in(third_port_in),
        .sync_out(p3_sync)
    );
    // ******************************************
    // register decode
    // ******************************************
    logic we1;
    logic we2;
    logic we3;
    logic wd1;
    logic wd2;
    logic wd3;
    always_comb begin
        we1 = wr_in && addr_in == `GPIO_FIRST_DATA;
        we2 = wr_in && addr_in == `GPIO_SECOND_DATA;
        we3 = wr_in && addr_in == `GPIO_THIRD_DATA;
        wd1 = wr_in && addr_in == `GPIO_FIRST_DIR;
        wd2 = wr_in && addr_in == `GPIO_SECOND_DIR;
        wd3 = wr_in && addr_in == `GPIO_THIRD_DIR;
    end
    // ******************************************
    // ports
    // ******************************************
    logic [FIRST_W-1:0] l1;
    logic [FIRST_W-1:0] d1;
    logic [SECOND_W-1:0] l2;
    logic [SECOND_W-1:0] d2;
    logic [THIRD_W-1:0] l3;
    logic [THIRD_W-1:0] d3;
    gpio_byte_t r1;
    gpio_byte_t r2;
    gpio_byte_t r3;
    gpio_byte_t rd1;
    gpio_byte_t rd2;
    gpio_byte_t rd3;
    gpio_port #(.WIDTH(FIRST_W)) u_first (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .data_we_in(we1),
        .dir_we_in(wd1),
        .wdata_in(wdata_in),
        .pad_sync_in(p1_sync),
        .latch_out(l1),
        .dir_out(d1),
        .data_rd_out(r1),
        .dir_rd_out(rd1)
    );
    gpio_port #(.WIDTH(SECOND_W)) u_second (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .data_we_in(we2),
        .dir_we_in(wd2),
        .wdata_in(wdata_in),
        .pad_sync_in(p2_sync),
        .latch_out(l2),
        .dir_out(d2),
        .data_rd_out(r2),
        .dir_rd_out(rd2)
    );
    gpio_port #(.WIDTH(THIRD_W)) u_third (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .data_we_in(we3),
        .dir_we_in(wd3),
        .wdata_in(wdata_in),
        .pad_sync_in(p3_sync),
        .latch_out(l3),
        .dir_out(d3),
        .data_rd_out(r3),
        .dir_rd_out(rd3)
    );
    // ******************************************
    // next state
    // ******************************************
    always_comb begin
        next_state = state;
        if (timer_overflow_in) begin
            next_state.tone = ~state.tone;
        end
        // read data captured at the phase edge, whole port for read-modify-write
        if (rd_in && second_instruction_phase_in) begin
            unique case (addr_in)
                `GPIO_FIRST_DATA: next_state.rdata = r1;
                `GPIO_FIRST_DIR: next_state.rdata = rd1;
                `GPIO_SECOND_DATA: next_state.rdata = r2;
                `GPIO_SECOND_DIR: next_state.rdata = rd2;
                `GPIO_THIRD_DATA: next_state.rdata = r3;
                `GPIO_THIRD_DIR: next_state.rdata = rd3;
                default: next_state.rdata = 8'h00;
            endcase
        end
        // push-pull drive; enable low while driving
        next_state.p1_o = l1;
        next_state.p1_oe_n = d1;
        next_state.p1_pull = {FIRST_W{opt_pull_first_in}};
        next_state.p2_o = l2;
        next_state.p2_oe_n = d2;
        next_state.p2_pull = {SECOND_W{opt_pull_second_in}};
        if (opt_buzzer_in) begin
            // bit 0 latch gates the tone for both lines
            next_state.p2_o[`GPIO_LINE_TONE] = l2[`GPIO_LINE_TONE] & state.tone;
            next_state.p2_o[`GPIO_LINE_TONE_N] = l2[`GPIO_LINE_TONE] & ~state.tone;
        end
        next_state.p3_o = l3;
        next_state.p3_oe_n = d3;
        next_state.p3_pull = {THIRD_W{opt_pull_third_in}};
        if (!opt_rc_io_in) begin
            next_state.p3_oe_n[`GPIO_LINE_OSC_IN] = 1'b1;
            next_state.p3_oe_n[`GPIO_LINE_OSC_OUT] = 1'b1;
            next_state.p3_pull[`GPIO_LINE_OSC_IN] = 1'b0;
            next_state.p3_pull[`GPIO_LINE_OSC_OUT] = 1'b0;
        end
        // shared pad functions seen from the pad level
        next_state.irq_n = p3_sync[0];
        next_state.tmr_clk = p3_sync[1];
        // wake on any change of an input line of the first port
        next_state.p1_prev = p1_sync;
        next_state.wake = opt_wake_first_in && |((p1_sync ^ state.p1_prev) & d1);
    end
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state <= '0;
            state.p1_oe_n <= '1;
            state.p2_oe_n <= '1;
            state.p3_oe_n <= '1;
            state.irq_n <= 1'b1;
            // match the synchronisers' idle level: no false wake or clock edge
            state.tmr_clk <= 1'b1;
            state.p1_prev <= '1;
        end else begin
            state <= next_state;
        end
    end
    // ******************************************
    // outputs
    // ******************************************
    assign rdata_out = state.rdata;
    assign first_port_out = state.p1_o;
    assign first_port_oe_n_out = state.p1_oe_n;
    assign first_port_pull_out = state.p1_pull;
    assign second_port_out = state.p2_o;
    assign second_port_oe_n_out = state.p2_oe_n;
    assign second_port_pull_out = state.p2_pull;
    assign third_port_out = state.p3_o;
    assign third_port_oe_n_out = state.p3_oe_n;
    assign third_port_pull_out = state.p3_pull;
    assign ext_interrupt_n_out = state.irq_n;
    assign timer_ext_clock_pin_out = state.tmr_clk;
    assign wake_out = state.wake;
endmodule // gpio_top

// ==== dv/bio_gpio_properties.sv ====
// checker for the three-port i/o block, watching top-level ports only
// assumes one clock and an active-low asynchronous reset
`timescale 1ns/1ps
module bio_gpio_checks #(
    parameter int FIRST_W = 8,
    parameter int SECOND_W = 8,
    parameter int THIRD_W = 5
) (
    input wire logic clk_in, reset_n_in, wr_in, rd_in, second_instruction_phase_in,
    input wire logic opt_wake_first_in, opt_buzzer_in, opt_rc_io_in, wake_out,
    input wire gpio_pkg::gpio_addr_t addr_in,
    input wire gpio_pkg::gpio_byte_t wdata_in, rdata_out,
    input wire logic [FIRST_W-1:0] first_port_in, first_port_out, first_port_oe_n_out,
    input wire logic [SECOND_W-1:0] second_port_out, second_port_oe_n_out,
    input wire logic [THIRD_W-1:0] third_port_oe_n_out, third_port_pull_out
);
    import gpio_pkg::*;
    // ****
    // port checks
    // ****
    default clocking @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    a_reset_quiet:
        assert property ($rose(reset_n_in) |-> &{first_port_oe_n_out, second_port_oe_n_out, third_port_oe_n_out})
        else $error("line driven after reset");
    a_dir_drive:
        assert property (wr_in && addr_in == 8'h13 |-> ##2 first_port_oe_n_out == $past(wdata_in, 2))
        else $error("direction not on pads");
    a_latch_out:
        assert property (wr_in && addr_in == 8'h12 |-> ##2
            ((first_port_out ^ $past(wdata_in, 2)) & ~first_port_oe_n_out) == '0) else $error("latch not on pads");
    a_upper_zero:
        assert property (rd_in && second_instruction_phase_in && addr_in == 8'h16 |=> rdata_out[7:5] == 3'b000)
        else $error("third port upper bits set");
    a_buzz_pair:
        assert property (opt_buzzer_in ##1 (opt_buzzer_in && second_port_oe_n_out[1:0] == 2'b00)
            |-> !(second_port_out[0] && second_port_out[1])) else $error("tone pair not complementary");
    a_buzz_gate:
        assert property ((opt_buzzer_in && wr_in && addr_in == 8'h14 && !wdata_in[0]) ##1 !(wr_in && addr_in == 8'h14)
            |=> second_port_oe_n_out[0] || (second_port_out[1:0] & ~second_port_oe_n_out[1:0]) == 2'b00)
        else $error("tone not gated low");
    a_rc_off:
        assert property (!opt_rc_io_in ##1 !opt_rc_io_in |-> third_port_oe_n_out[4:3] == 2'b11
            && third_port_pull_out[4:3] == 2'b00) else $error("oscillator lines active");
    a_wake_seen:
        assert property (opt_wake_first_in && $past(reset_n_in, 4) && $changed(first_port_in)
            && &first_port_oe_n_out |-> ##[1:6] wake_out) else $error("no wake pulse");
endmodule // bio_gpio_checks
bind gpio_top bio_gpio_checks #(.FIRST_W(FIRST_W), .SECOND_W(SECOND_W), .THIRD_W(THIRD_W)) u_checks (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .wr_in(wr_in),
    .rd_in(rd_in),
    .second_instruction_phase_in(second_instruction_phase_in),
    .opt_wake_first_in(opt_wake_first_in),
    .opt_buzzer_in(opt_buzzer_in),
    .opt_rc_io_in(opt_rc_io_in),
    .wake_out(wake_out),
    .addr_in(addr_in),
    .wdata_in(wdata_in),
    .rdata_out(rdata_out),
    .first_port_in(first_port_in),
    .first_port_out(first_port_out),
    .first_port_oe_n_out(first_port_oe_n_out),
    .second_port_out(second_port_out),
    .second_port_oe_n_out(second_port_oe_n_out),
    .third_port_oe_n_out(third_port_oe_n_out),
    .third_port_pull_out(third_port_pull_out)
);

// ==== dv/bio_pad_model.sv ====
// board side of the pads: buttons drive idle lines, pulls or float otherwise
// assumes oe_n low means the device drives the line
`timescale 1ns/1ps
module bio_pad_model #(
    parameter int W = 21
) (
    input wire logic clk_in,
    input wire logic [W-1:0] out_in, oe_n_in, pull_in, ext_en_in, ext_val_in,
    output logic [W-1:0] pad_out
);
    logic [W-1:0] noise = '0;
    // a floating line shows a changing pattern
    always @(posedge clk_in) noise <= ~noise;
    always_comb begin
        for (int i = 0; i < W; i++) begin
            if (!oe_n_in[i]) pad_out[i] = out_in[i];
            else if (ext_en_in[i]) pad_out[i] = ext_val_in[i];
            else if (pull_in[i]) pad_out[i] = 1'b1;
            else pad_out[i] = noise[i];
        end
    end
endmodule // bio_pad_model

// ==== dv/tb_bidir_io_ports_buzzer_share.sv ====
// self-checking bench for the three-port i/o block
// assumes the pad model and the checker are compiled first
`timescale 1ns/1ps
`define CHK(g, e, m) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
    $display("Error %0t: %s %h/%h", $time, m, g, e); end end
module tb_bidir_io_ports_buzzer_share;
    import gpio_pkg::*;
    logic clk_in = 0, reset_n_in = 0, wr_in = 0, rd_in = 0, ph = 0, ovf = 0, irq_n, tclk, wake_out, w;
    logic wk = 1, bz = 0, rc = 1;
    logic [2:0] pu = 3'b111;
    gpio_addr_t addr_in = '0;
    gpio_byte_t wdata_in = '0, rdata_out;
    logic [20:0] ext = '0, en = '1, pin, pout, poe, ppu;
    int seed = 8, mismatches = 0, n_tests = 0, a, tone = 0;
    int lat[3] = '{'hff, 'hff, 'h1f}, dir[3] = '{'hff, 'hff, 'h1f}, wm[3] = '{'hff, 'hff, 'h1f};
    gpio_top dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .addr_in(addr_in), .wr_in(wr_in), .rd_in(rd_in),
        .wdata_in(wdata_in), .rdata_out(rdata_out), .second_instruction_phase_in(ph), .timer_overflow_in(ovf),
        .opt_wake_first_in(wk), .opt_pull_first_in(pu[0]), .opt_pull_second_in(pu[1]), .opt_pull_third_in(pu[2]),
        .opt_buzzer_in(bz), .opt_rc_io_in(rc), .first_port_in(pin[7:0]), .first_port_out(pout[7:0]),
        .first_port_oe_n_out(poe[7:0]), .first_port_pull_out(ppu[7:0]), .second_port_in(pin[15:8]),
        .second_port_out(pout[15:8]), .second_port_oe_n_out(poe[15:8]), .second_port_pull_out(ppu[15:8]),
        .third_port_in(pin[20:16]), .third_port_out(pout[20:16]), .third_port_oe_n_out(poe[20:16]),
        .third_port_pull_out(ppu[20:16]), .ext_interrupt_n_out(irq_n), .timer_ext_clock_pin_out(tclk),
        .wake_out(wake_out));
    bio_pad_model #(.W(21)) pads (.clk_in(clk_in), .out_in(pout), .oe_n_in(poe), .pull_in(ppu),
        .ext_en_in(en), .ext_val_in(ext), .pad_out(pin));
    // ****
    // bus tasks and model
    // ****
    initial forever #25 clk_in = ~clk_in;
    task automatic bus(input logic wv, rv, input int av, dv);
        wr_in = wv;
        rd_in = rv;
        ph = rv;
        addr_in = gpio_addr_t'(av);
        wdata_in = gpio_byte_t'(dv);
        @(posedge clk_in);
        #1;
    endtask
    task automatic idle(input int n);
        repeat (n) bus(0, 0, 0, 0);
    endtask
    function automatic int exp_rd(input int av);
        int p;
        p = (av - 'h12) / 2;
        if (av < 'h12 || av > 'h17) return 0;
        if (av % 2) return dir[p];
        return ((int'(ext >> (8 * p)) & dir[p]) | (lat[p] & ~dir[p])) & wm[p];
    endfunction
    task automatic op(input int kv, av, dv);
        gpio_byte_t g;
        int p;
        p = (av - 'h12) / 2;
        if (kv == 0) begin
            bus(1, 0, av, dv);
            if (av >= 'h12 && av <= 'h17 && av % 2) dir[p] = dv & wm[p];
            else if (av >= 'h12 && av <= 'h17) lat[p] = dv & wm[p];
        end else begin
            bus(0, 1, av, 0);
            g = rdata_out & gpio_byte_t'(av == 'h17 ? 'h1f : 'hff);
            `CHK(g, gpio_byte_t'(exp_rd(av)), "read")
            if (kv == 2) op(0, av, ~g);
        end
    endtask
    task automatic padchk();
        logic [20:0] d, l;
        d = {dir[2][4:0], dir[1][7:0], dir[0][7:0]};
        l = {lat[2][4:0], lat[1][7:0], lat[0][7:0]};
        `CHK(poe, d, "enable")
        `CHK(pout & ~d, l & ~d, "level")
    endtask
    task automatic finish_test();
        $display("checks %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // ****
    // tests
    // ****
    initial begin
        idle(20);
        reset_n_in = 1;
        `CHK(poe, 21'h1f_ffff, "reset")
        idle(2);
        for (a = 'h12; a < 'h18; a++) op(1, a, 0);
        $display("reset test done");
        for (int i = 0; i < 80; i++) begin
            ext = 21'($random(seed));
            idle(3);
            op({$random(seed)} % 3, 'h10 + {$random(seed)} % 10, $random(seed) & 'hff);
            idle(3);
            padchk();
        end
        op(0, 'h15, 'h5a);
        op(1, 'h15, 0);
        $display("random test done");
        reset_n_in = 0;
        idle(2);
        reset_n_in = 1;
        lat = '{'hff, 'hff, 'h1f};
        dir = '{'hff, 'hff, 'h1f};
        `CHK(poe, 21'h1f_ffff, "reset")
        idle(2);
        for (a = 'h12; a < 'h18; a++) op(1, a, 0);
        @(posedge clk_in);
        #1;
        ph = 0;
        addr_in = 8'h13;
        @(posedge clk_in);
        #1;
        `CHK(rdata_out, gpio_byte_t'(dir[2]), "phase")
        $display("second reset test done");
        bz = 1;
        op(0, 'h15, 0);
        op(0, 'h14, 1);
        idle(3);
        for (int i = 0; i < 4; i++) begin
            ovf = 1;
            idle(1);
            ovf = 0;
            tone = 1 - tone;
            idle(3);
            `CHK(pout[9:8], 2'(tone ? 1 : 2), "tone")
        end
        op(0, 'h14, 0);
        idle(3);
        `CHK(pout[9:8], 2'b00, "gate")
        op(0, 'h15, 3);
        ext[9:8] = 2'b10;
        idle(4);
        op(1, 'h14, 0);
        bz = 0;
        $display("buzzer test done");
        op(0, 'h13, 'hff);
        for (int i = 0; i < 2; i++) begin
            wk = (i == 0);
            idle(4);
            ext[0] = !ext[0];
            w = 0;
            repeat (6) begin
                idle(1);
                w |= wake_out;
            end
            `CHK(w, (i == 0), "wake")
        end
        op(0, 'h17, 'hff);
        ext[17:16] = 2'b01;
        idle(5);
        `CHK({tclk, irq_n}, 2'b01, "shared")
        rc = 0;
        pu = 3'b010;
        op(0, 'h17, 0);
        idle(4);
        `CHK(poe[20:19], 2'b11, "osc")
        `CHK(ppu, 21'h0_ff00, "pull")
        pu = 3'b101;
        rc = 1;
        idle(3);
        `CHK(ppu, 21'h1f_00ff, "pull")
        for (a = 'h13; a < 'h18; a += 2) op(0, a, 0);
        $display("option test done");
        finish_test();
    end
    initial begin
        #2_000_000;
        mismatches++;
        finish_test();
    end
endmodule // tb_bidir_io_ports_buzzer_share
